/* File: rtc_pkg.sv */
package rtc_pkg;

    // Counter widths
    localparam int TOD_W = 17;
    localparam int DAY_W = 15;
    localparam int CAL_W = 5;
    localparam int DIV_W = 16;

    // Time base: 32768 counts of the 32 kHz clock make one second
    localparam int DIV_COUNTS = 32768;
    localparam logic [DIV_W-1:0] DIV_TERM = 16'h7FFF;

    // Last second of the day (86,399)
    localparam logic [TOD_W-1:0] TOD_MAX = 17'h1517F;

    // Register byte offsets
    localparam logic [4:0] OFS_CTRL    = 5'h00;
    localparam logic [4:0] OFS_TIME    = 5'h04;
    localparam logic [4:0] OFS_DAY     = 5'h08;
    localparam logic [4:0] OFS_ALM_SEC = 5'h0C;
    localparam logic [4:0] OFS_ALM_DAY = 5'h10;
    localparam logic [4:0] OFS_STATUS  = 5'h14;

    // Control register fields
    localparam int CTRL_DIS_BIT    = 0;
    localparam int CTRL_KEEP_BIT   = 1;
    localparam int CTRL_AMASK_BIT  = 2;
    localparam int CTRL_TMASK_BIT  = 3;
    localparam int CTRL_MODE_LSB   = 4;
    localparam int CTRL_CAL_LSB    = 8;

    // Status register fields, write one to clear
    localparam int STAT_TICK_BIT   = 0;
    localparam int STAT_ALARM_BIT  = 1;
    localparam int STAT_RST_BIT    = 2;

    // Calibration enable codes
    localparam logic [1:0] CAL_MODE_OFF  = 2'h0;
    localparam logic [1:0] CAL_MODE_MAIN = 2'h1;
    localparam logic [1:0] CAL_MODE_ALL  = 2'h3;

    // Reset values
    localparam logic [TOD_W-1:0] ALM_SEC_RST = 17'h1FFFF;
    localparam logic [DAY_W-1:0] ALM_DAY_RST = 15'h7FFF;
    localparam logic [CAL_W-1:0] CAL_RST     = 5'h00;

    // Bus handshake states
    typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} rtc_bus_state_type;

endpackage : rtc_pkg

/* File: rtc_div.sv */
module rtc_div (
    // Clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        rst,
    // Time base and control
    input  wire logic                        osc_tick,
    input  wire logic                        run,
    input  wire logic                        cal_on,
    input  wire logic [rtc_pkg::CAL_W-1:0]   cal_word,
    // One-second strobe
    output logic                             sec_tick
);
    import rtc_pkg::*;

    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] term;
    logic [DIV_W-1:0] next_term;
    logic signed [DIV_W:0] cal_term;

    // Signed correction shortens or stretches each period
    always_comb begin
        cal_term = $signed({1'b0, DIV_TERM})
                 - $signed({{(DIV_W+1-CAL_W){cal_word[CAL_W-1]}}, cal_word});
        next_term = cal_on ? cal_term[DIV_W-1:0] : DIV_TERM;
    end

    // Term is taken once per period so a mid-second write never tears it
    always_ff @(posedge core_clk) begin
        if (rst) begin
            count    <= '0;
            term     <= DIV_TERM;
            sec_tick <= 1'b0;
        end else begin
            sec_tick <= 1'b0;
            if (!run) begin
                count <= '0;
                term  <= next_term;
            end else if (osc_tick) begin
                if (count >= term) begin
                    count    <= '0;
                    sec_tick <= 1'b1;
                    term     <= next_term;
                end else begin
                    count <= count + 16'h0001;
                end
            end
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    a_div_period: assert property (
        run && osc_tick && count >= term |=> sec_tick && count == '0)
        else $error("divider missed its terminal count");

endmodule : rtc_div

/* File: rtc_core.sv */
// Functional notes
// - Keep mode set: cpu slow clock driven in every state.
// - Keep mode clear: cpu slow clock stopped while system is off.
// - Secure clock wake on power key treated as ordinary key press.
// - Secure supply enable asserts from backup reset, never switchable off.
// - Disable bit stops the clock; clock runs by default.
// - Divide time base to one-second tick, advancing 17-bit seconds counter.
// - Seconds counter runs 0 to 86,399 then returns to 0.
// - Each seconds roll-over increments 15-bit day counter up to 32767.
// - Each tick sets tick flag; interrupts only when its mask clear.
// - Alarm flag set when seconds and day both equal alarm values.
// - Unmasked alarm interrupts when on, turns system on when off.
// - Backup reset loads alarm seconds and day with all ones.
// - Alarm flag kept in backup storage, valid at power up.
// - Alarm mask resets to one.
// - Backup reset clears counters and backup registers, sets alarm values to all ones.
// - Backup reset sets the clock-reset flag.
// - Five-bit signed calibration, minus sixteen to plus fifteen counts.
// - Calibration touches only the second divider, not clock outputs.
// - Cal mode 00 off, 01 off on backup cell, 11 always.
// - Mode 01 drops calibration while running from backup cell.
//
// Added by the designer: the register offsets and the Avalon-MM register port.
module rtc_core (
    // Clock and backup power-on reset
    input  wire logic                  core_clk,
    input  wire logic                  rst,
    // Avalon-MM slave
    input  wire logic [4:0]            avs_address,
    input  wire logic                  avs_read,
    input  wire logic                  avs_write,
    input  wire logic [31:0]           avs_writedata,
    input  wire logic [3:0]            avs_byteenable,
    output logic      [31:0]           avs_readdata,
    output logic                       avs_waitrequest,
    // Time base and system status
    input  wire logic                  osc_level,
    input  wire logic                  system_on,
    input  wire logic                  on_backup_cell,
    input  wire logic                  power_key_pin_n,
    // Outputs to system
    output logic                       irq,
    output logic                       turn_on_request,
    output logic                       cpu_slow_clock_out,
    output logic                       peripheral_slow_clock_out,
    output logic                       secure_rtc_supply_en
);
    import rtc_pkg::*;

    rtc_bus_state_type     bus_state;
    logic                  osc_level_d;
    logic                  osc_tick;
    logic                  sec_tick;
    logic                  eval;
    logic                  cal_on;
    logic                  wr_go;
    logic [31:0]           wr_mask;
    logic [31:0]           rd_mux;
    logic [31:0]           ctrl_word;
    logic [31:0]           stat_word;
    logic [31:0]           next_ctrl;
    logic [31:0]           next_val;
    logic                  alarm_match;
    logic                  alarm_wake;
    logic                  key_press;

    // Software controls
    logic                  rtc_disable;
    logic                  keep_clock_mode;
    logic                  alarm_mask;
    logic                  tick_mask;
    logic [1:0]            cal_enable_mode;
    logic [CAL_W-1:0]      cal_word;

    // Clock state, all on backup power
    logic [TOD_W-1:0]      seconds_of_day_count;
    logic [DAY_W-1:0]      day_count;
    logic [TOD_W-1:0]      alarm_seconds;
    logic [DAY_W-1:0]      alarm_day;
    logic                  second_tick_irq;
    logic                  alarm_irq;
    logic                  rtc_reset_irq;

    // Rising edge of the sampled 32 kHz clock is the divider step
    always_ff @(posedge core_clk) begin
        if (rst) begin
            osc_level_d <= 1'b0;
        end else begin
            osc_level_d <= osc_level;
        end
    end

    assign osc_tick = osc_level & ~osc_level_d;

    // Mode 10 is left undefined for software and falls to off here
    assign cal_on = (cal_enable_mode == CAL_MODE_ALL)
                  | ((cal_enable_mode == CAL_MODE_MAIN)
                     & ~on_backup_cell);

    rtc_div u_div (
        .core_clk (core_clk),
        .rst      (rst),
        .osc_tick (osc_tick),
        .run      (~rtc_disable),
        .cal_on   (cal_on),
        .cal_word (cal_word),
        .sec_tick (sec_tick)
    );

    // Byte-enable mask for partial writes
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wr_mask[i*8 +: 8] = {8{avs_byteenable[i]}};
        end
    end

    assign wr_go = (bus_state == BUS_ACK) & avs_write;

    // Register images for readback
    always_comb begin
        ctrl_word = '0;
        ctrl_word[CTRL_DIS_BIT]   = rtc_disable;
        ctrl_word[CTRL_KEEP_BIT]  = keep_clock_mode;
        ctrl_word[CTRL_AMASK_BIT] = alarm_mask;
        ctrl_word[CTRL_TMASK_BIT] = tick_mask;
        ctrl_word[CTRL_MODE_LSB +: 2]     = cal_enable_mode;
        ctrl_word[CTRL_CAL_LSB +: CAL_W]  = cal_word;
        stat_word = '0;
        stat_word[STAT_TICK_BIT]  = second_tick_irq;
        stat_word[STAT_ALARM_BIT] = alarm_irq;
        stat_word[STAT_RST_BIT]   = rtc_reset_irq;
    end

    // Read decode; unmapped offsets read as zero
    always_comb begin
        rd_mux = '0;
        unique case (avs_address)
            OFS_CTRL:    rd_mux = ctrl_word;
            OFS_TIME:    rd_mux[TOD_W-1:0] = seconds_of_day_count;
            OFS_DAY:     rd_mux[DAY_W-1:0] = day_count;
            OFS_ALM_SEC: rd_mux[TOD_W-1:0] = alarm_seconds;
            OFS_ALM_DAY: rd_mux[DAY_W-1:0] = alarm_day;
            OFS_STATUS:  rd_mux = stat_word;
            default:     rd_mux = '0;
        endcase
    end

    // Byte-masked write value for all plain registers; only control merges with its old bits
    assign next_val  = avs_writedata & wr_mask;
    assign next_ctrl = (ctrl_word & ~wr_mask) | next_val;

    // One wait cycle per access, so read data come from a register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bus_state       <= BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= '0;
        end else begin
            unique case (bus_state)
                BUS_IDLE: begin
                    if (avs_read || avs_write) begin
                        bus_state       <= BUS_ACK;
                        avs_waitrequest <= 1'b0;
                        avs_readdata    <= avs_read ? rd_mux : '0;
                    end
                end
                BUS_ACK: begin
                    bus_state       <= BUS_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // Control register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rtc_disable     <= 1'b0;
            keep_clock_mode <= 1'b0;
            alarm_mask      <= 1'b1;
            tick_mask       <= 1'b1;
            cal_enable_mode <= CAL_MODE_OFF;
            cal_word        <= CAL_RST;
        end else if (wr_go && avs_address == OFS_CTRL) begin
            rtc_disable     <= next_ctrl[CTRL_DIS_BIT];
            keep_clock_mode <= next_ctrl[CTRL_KEEP_BIT];
            alarm_mask      <= next_ctrl[CTRL_AMASK_BIT];
            tick_mask       <= next_ctrl[CTRL_TMASK_BIT];
            cal_enable_mode <= next_ctrl[CTRL_MODE_LSB +: 2];
            cal_word        <= next_ctrl[CTRL_CAL_LSB +: CAL_W];
        end
    end

    // Seconds and day counters; a software write beats the tick
    always_ff @(posedge core_clk) begin
        if (rst) begin
            seconds_of_day_count <= '0;
            day_count            <= '0;
        end else begin
            if (sec_tick) begin
                if (seconds_of_day_count == TOD_MAX) begin
                    seconds_of_day_count <= '0;
                    day_count <= day_count + 15'h0001;
                end else begin
                    seconds_of_day_count <= seconds_of_day_count
                                          + 17'h00001;
                end
            end
            if (wr_go && avs_address == OFS_TIME) begin
                seconds_of_day_count <= next_val[TOD_W-1:0];
            end
            if (wr_go && avs_address == OFS_DAY) begin
                day_count <= next_val[DAY_W-1:0];
            end
        end
    end

    // Alarm values
    always_ff @(posedge core_clk) begin
        if (rst) begin
            alarm_seconds <= ALM_SEC_RST;
            alarm_day     <= ALM_DAY_RST;
        end else begin
            if (wr_go && avs_address == OFS_ALM_SEC) begin
                alarm_seconds <= next_val[TOD_W-1:0];
            end
            if (wr_go && avs_address == OFS_ALM_DAY) begin
                alarm_day <= next_val[DAY_W-1:0];
            end
        end
    end

    // Compare one cycle after a tick, once the counters have moved
    always_ff @(posedge core_clk) begin
        if (rst) begin
            eval <= 1'b0;
        end else begin
            eval <= sec_tick;
        end
    end

    assign alarm_match = eval
                       && seconds_of_day_count == alarm_seconds
                       && day_count == alarm_day;

    // Sticky flags: set wins over a write-one clear in the same cycle
    always_ff @(posedge core_clk) begin
        if (rst) begin
            second_tick_irq <= 1'b0;
            alarm_irq       <= 1'b0;
            rtc_reset_irq   <= 1'b1;
        end else begin
            if (wr_go && avs_address == OFS_STATUS) begin
                if (next_val[STAT_TICK_BIT]) begin
                    second_tick_irq <= 1'b0;
                end
                if (next_val[STAT_ALARM_BIT]) begin
                    alarm_irq <= 1'b0;
                end
                if (next_val[STAT_RST_BIT]) begin
                    rtc_reset_irq <= 1'b0;
                end
            end
            if (sec_tick) begin
                second_tick_irq <= 1'b1;
            end
            if (alarm_match) begin
                alarm_irq <= 1'b1;
            end
        end
    end

    assign alarm_wake = alarm_irq & ~alarm_mask;
    assign key_press  = ~power_key_pin_n;

    // Interrupt only while on; alarm wakes the system only while off
    always_ff @(posedge core_clk) begin
        if (rst) begin
            irq             <= 1'b0;
            turn_on_request <= 1'b0;
        end else begin
            irq <= system_on
                 & ((second_tick_irq & ~tick_mask)
                    | alarm_wake | rtc_reset_irq);
            turn_on_request <= ~system_on
                             & (alarm_wake | key_press);
        end
    end

    // Slow clock drivers follow the oscillator, never the calibration
    always_ff @(posedge core_clk) begin
        if (rst) begin
            cpu_slow_clock_out        <= 1'b0;
            peripheral_slow_clock_out <= 1'b0;
        end else begin
            cpu_slow_clock_out <= osc_level
                                & (keep_clock_mode | system_on);
            peripheral_slow_clock_out <= osc_level & system_on;
        end
    end

    // Supply enable has no off control and needs no reset branch
    always_ff @(posedge core_clk) begin
        secure_rtc_supply_en <= 1'b1;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_rollover;
        sec_tick && seconds_of_day_count == TOD_MAX
            && !(wr_go && avs_address == OFS_DAY);
    endsequence

    sequence s_step;
        sec_tick && seconds_of_day_count != TOD_MAX
            && !(wr_go && avs_address == OFS_TIME);
    endsequence

    a_tod_step: assert property (
        s_step |=> seconds_of_day_count
                   == $past(seconds_of_day_count) + 17'h00001)
        else $error("seconds counter did not step");
    a_tod_wrap: assert property (
        s_rollover ##0 !(wr_go && avs_address == OFS_TIME)
            |=> seconds_of_day_count == '0)
        else $error("seconds counter did not wrap");
    a_day_step: assert property (
        s_rollover |=> day_count == $past(day_count) + 15'h0001)
        else $error("day counter did not step");
    a_tick_flag: assert property (
        sec_tick |=> second_tick_irq)
        else $error("tick flag not set");
    a_alarm_hit: assert property (
        alarm_match |=> alarm_irq)
        else $error("alarm flag not set on match");
    a_alarm_wake: assert property (
        alarm_irq && !alarm_mask && !system_on |=> turn_on_request)
        else $error("unmasked alarm failed to wake");
    a_alarm_quiet: assert property (
        alarm_mask && power_key_pin_n && !second_tick_irq
            && !rtc_reset_irq |=> !turn_on_request && !irq)
        else $error("masked alarm acted");
    a_cpu_clk_keep: assert property (
        keep_clock_mode && osc_level |=> cpu_slow_clock_out)
        else $error("cpu slow clock dropped in keep mode");
    a_cpu_clk_off: assert property (
        !keep_clock_mode && !system_on |=> !cpu_slow_clock_out)
        else $error("cpu slow clock ran while off");
    a_disable_hold: assert property (
        rtc_disable && !$past(sec_tick) ##1 !wr_go [*2]
            |-> $stable(seconds_of_day_count))
        else $error("clock advanced while disabled");
    a_supply_on: assert property (
        $rose(system_on) |-> secure_rtc_supply_en)
        else $error("secure supply enable low");
    a_bus_answer: assert property (
        bus_state == BUS_IDLE && (avs_read || avs_write)
            |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not one wait cycle");

endmodule : rtc_core

/* File: rtc_sys_model.sv */
// Stands in for the processor side: slow time base and secure wake line
module rtc_sys_model (
    // Clock
    input  wire logic core_clk,
    // Controls from the bench
    input  wire logic osc_en,
    input  wire logic wake_req,
    input  wire logic user_key,
    // Lines toward the block
    output logic      osc_level,
    output logic      power_key_pin_n,
    output int        osc_edges
);
    timeunit 1ns;
    timeprecision 1ps;

    // Fastest legal time base, two core cycles per count, idles low
    initial osc_level = 1'b0;
    initial osc_edges = 0;
    always @(posedge core_clk) begin
        if (osc_en) begin
            osc_level <= ~osc_level;
            if (!osc_level) osc_edges <= osc_edges + 1;
        end else begin
            osc_level <= 1'b0;
        end
    end

    // Open drain wake in parallel with the key; pull-up gives high
    assign power_key_pin_n = (wake_req | user_key) ? 1'b0 : 1'b1;
endmodule : rtc_sys_model

/* File: tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import rtc_pkg::*;

    typedef struct packed {
        logic        wr;
        logic [4:0]  a;
        logic [31:0] d;
        logic [31:0] x;
    } rtc_row_type;

    logic        core_clk, rst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, rd;
    logic [3:0]  avs_byteenable;
    logic        osc_level, system_on, on_backup_cell, power_key_pin_n;
    logic        irq, turn_on_request, cpu_slow_clock_out;
    logic        peripheral_slow_clock_out, secure_rtc_supply_en;
    logic        osc_en, wake_req, user_key;
    int          osc_edges, n_mismatch, compares, n_cpu, n_per, c, c2, e;

    // Reset rows first, then write and read back rows
    localparam rtc_row_type ROWS [14] = '{
        '{1'b0, OFS_CTRL,    32'h0, 32'h0000000C},
        '{1'b0, OFS_TIME,    32'h0, 32'h00000000},
        '{1'b0, OFS_DAY,     32'h0, 32'h00000000},
        '{1'b0, OFS_ALM_SEC, 32'h0, 32'h0001FFFF},
        '{1'b0, OFS_ALM_DAY, 32'h0, 32'h00007FFF},
        '{1'b0, OFS_STATUS,  32'h0, 32'h00000004},
        '{1'b0, 5'h18,       32'h0, 32'h00000000},
        '{1'b1, OFS_TIME,    32'h0001517F, 32'h0001517F},
        '{1'b1, OFS_DAY,     32'hFFFFFFFF, 32'h00007FFF},
        '{1'b1, OFS_ALM_SEC, 32'h00000000, 32'h00000000},
        '{1'b1, 5'h18,       32'hFFFFFFFF, 32'h00000000},
        '{1'b1, OFS_STATUS,  32'h00000004, 32'h00000000},
        '{1'b1, OFS_CTRL,    32'hFFFFFFFF, 32'h00001F3F},
        '{1'b1, OFS_CTRL,    32'h0000000C, 32'h0000000C}
    };

    rtc_core dut_u (
        .core_clk(core_clk), .rst(rst),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .osc_level(osc_level),
        .system_on(system_on), .on_backup_cell(on_backup_cell),
        .power_key_pin_n(power_key_pin_n), .irq(irq),
        .turn_on_request(turn_on_request),
        .cpu_slow_clock_out(cpu_slow_clock_out),
        .peripheral_slow_clock_out(peripheral_slow_clock_out),
        .secure_rtc_supply_en(secure_rtc_supply_en)
    );

    rtc_sys_model model_u (
        .core_clk(core_clk), .osc_en(osc_en), .wake_req(wake_req),
        .user_key(user_key), .osc_level(osc_level),
        .power_key_pin_n(power_key_pin_n), .osc_edges(osc_edges)
    );

    // 200 MHz core clock
    initial core_clk = 1'b0;
    always #2.5 core_clk = ~core_clk;

    // Count slow clock rises, cleared by the tests
    always @(posedge cpu_slow_clock_out) n_cpu++;
    always @(posedge peripheral_slow_clock_out) n_per++;

    task conclude;
        $display("compares=%0d mismatches=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : conclude

    task check_word(input logic [31:0] got, input logic [31:0] x,
                    input string m);
        compares++;
        if (got !== x) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, m, got, x);
        end
    endtask : check_word

    task check_bit(input logic got, input logic x, input string m);
        compares++;
        if (got !== x) begin
            n_mismatch++;
            $display("MISMATCH t=%0t %s got %b", $time, m, got);
        end
    endtask : check_bit

    // Request held until the edge that samples waitrequest low
    task bus_op(input logic wr, input logic [4:0] a, input logic [31:0] d,
                output logic [31:0] q);
        int n;
        n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        @(posedge core_clk);
        while (avs_waitrequest !== 1'b0 && n < 20) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 20) check_bit(1'b0, 1'b1, "bus timeout");
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge core_clk);
    endtask : bus_op

    // Bounded wait on irq (sel 0) or turn_on_request (sel 1)
    task wait_for(input bit sel, input logic v, output int n);
        n = 0;
        while (((sel ? turn_on_request : irq) !== v) && n < 70000) begin
            @(posedge core_clk);
            n++;
        end
        if (n >= 70000) check_bit(~v, v, "wait timeout");
    endtask : wait_for

    // Time base runs only for the count given, then rests low
    task run_osc(input int n);
        osc_en <= 1'b1;
        repeat (2 * n) @(posedge core_clk);
        osc_en <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask : run_osc

    task do_reset;
        rst <= 1'b1;
        repeat (4) @(posedge core_clk);
        check_bit(secure_rtc_supply_en, 1'b1, "supply in reset");
        rst <= 1'b0;
        @(posedge core_clk);
    endtask : do_reset

    // Hang guard: well past the one-second run
    initial begin
        #500000;
        check_bit(1'b0, 1'b1, "watchdog");
        conclude;
    end

    initial begin
        {rst, avs_read, avs_write, osc_en, wake_req, user_key} = 6'h20;
        {system_on, on_backup_cell, n_cpu, n_per} = '0;
        {n_mismatch, compares} = '0;
        avs_address = 5'h00;
        avs_writedata = 32'h0;
        avs_byteenable = 4'hF;
        @(posedge core_clk);
        do_reset;
        for (int i = 0; i < 14; i++) begin
            bus_op(ROWS[i].wr, ROWS[i].a, ROWS[i].d, rd);
            if (ROWS[i].wr) bus_op(1'b0, ROWS[i].a, 32'h0, rd);
            check_word(rd, ROWS[i].x, $sformatf("r%0d", i));
        end
        check_bit(secure_rtc_supply_en, 1'b1, "supply");
        $display("test registers done");

        // System off: cpu clock follows keep mode, peripheral stays low
        {n_cpu, n_per} = '0;
        run_osc(20);
        check_word(n_cpu, 32'h0, "cpu clk keep off");
        bus_op(1'b1, OFS_CTRL, 32'h0000000E, rd);
        n_cpu = 0;
        run_osc(20);
        check_word(n_cpu, 32'h14, "cpu clk keep on");
        check_word(n_per, 32'h0, "periph clk off");
        $display("test slow clocks done");

        // Secure wake and key press must look the same
        wake_req <= 1'b1;
        wait_for(1'b1, 1'b1, c);
        wake_req <= 1'b0;
        wait_for(1'b1, 1'b0, e);
        user_key <= 1'b1;
        wait_for(1'b1, 1'b1, c2);
        user_key <= 1'b0;
        wait_for(1'b1, 1'b0, e);
        check_word(c, c2, "wake vs key latency");
        $display("test wake done");

        // One calibrated second across the end of a day, mode 11 on cell
        system_on <= 1'b1;
        on_backup_cell <= 1'b1;
        bus_op(1'b1, OFS_TIME, 32'h0001517F, rd);
        bus_op(1'b1, OFS_DAY, 32'h00007FFE, rd);
        bus_op(1'b1, OFS_ALM_SEC, 32'h00000000, rd);
        bus_op(1'b1, OFS_ALM_DAY, 32'h00007FFF, rd);
        bus_op(1'b1, OFS_CTRL, 32'h00000F31, rd);
        run_osc(100);
        bus_op(1'b1, OFS_CTRL, 32'h00000F30, rd);
        check_bit(irq, 1'b0, "irq before tick");
        e = osc_edges;
        n_per = 0;
        osc_en <= 1'b1;
        wait_for(1'b0, 1'b1, c);
        osc_en <= 1'b0;
        e = osc_edges - e;
        check_bit(e >= 32753 && e <= 32757, 1'b1, "cal period");
        check_bit(n_per >= e - 2 && n_per <= e, 1'b1, "periph clk");
        bus_op(1'b0, OFS_TIME, 32'h0, rd);
        check_word(rd, 32'h00000000, "time wrap");
        bus_op(1'b0, OFS_DAY, 32'h0, rd);
        check_word(rd, 32'h00007FFF, "day count");
        bus_op(1'b0, OFS_STATUS, 32'h0, rd);
        check_word(rd, 32'h00000003, "tick and alarm");
        system_on <= 1'b0;
        wait_for(1'b1, 1'b1, c);
        check_bit(irq, 1'b0, "irq while off");
        bus_op(1'b1, OFS_CTRL, 32'h00000F34, rd);
        wait_for(1'b1, 1'b0, c);
        bus_op(1'b0, OFS_STATUS, 32'h0, rd);
        check_word(rd, 32'h00000003, "alarm kept");
        $display("test second done");

        // Second reset in mid-run brings back every reset value again
        do_reset;
        for (int i = 0; i < 7; i++) begin
            bus_op(1'b0, ROWS[i].a, 32'h0, rd);
            check_word(rd, ROWS[i].x, $sformatf("rst2 %0d", i));
        end
        $display("test second reset done");
        conclude;
    end
endmodule : tb_top
